// *** hdl/acs_converter.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Start when chip select and read both low
// - Busy low during conversion, high after
// - Host waits for busy high before restart
// - Read right after busy rises: no restart
// - Hold input three input clocks after start
// - Track input between conversions
// - Near-edge strobe may shift sampling one clock
// - Host avoids strobes near falling clock edges
// - Divide input clock by two internally
// - Conversion lasts twenty input clocks
// - Two input clocks before first compare
// - Clear approximation register at conversion start
// - Stop internal clock when conversion ends
// - External clock may run between conversions
// - Four megahertz gives minimum conversion time
// - Read during conversion returns previous result
// - Host avoids reads during conversion
// - Port read starts, second read fetches
// - Host keeps bus quiet during conversion
module acs_converter
  import acs_pkg::*;
#(
  parameter int DW = DATA_W                 // Result width
)(
  // Clock, enable, reset
  input  wire logic          core_clk,
  input  wire logic          core_ce,
  input  wire logic          rst_n,
  // Host link
  acs_link_if.device         link,
  // Comparator side
  input  wire logic          cmp_high,      // Trial level above held sample
  output logic               track,         // High: sampling stage follows input
  output logic [DW-1:0]      trial_code     // Level under test
);

  // Conversion states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,   // Tracking, waiting for a start
    ST_ACQ   = 4'b0010,   // Started, counting past the hold edge to the fourth falling edge
    ST_CONV  = 4'b0100,   // Successive approximation running
    ST_GRACE = 4'b1000    // One input clock after busy rises
  } acs_state_t;

  // All state in one packed struct
  typedef struct packed {
    logic [1:0]    cs_s;      // Chip select synchroniser
    logic [1:0]    rd_s;      // Read strobe synchroniser
    logic [1:0]    clk_s;     // Input clock synchroniser
    logic          clk_d;     // Last synchronised input clock
    logic          sel_d;     // Last combined select
    logic          div;       // Divided internal clock
    acs_state_t    st;        // Sequencer state
    logic [CNT_W-1:0] cnt;    // Falling input-clock edges since start
    logic [DW-1:0] successive_approx_register;       // Approximation register
    logic [DW-1:0] bitm;      // Bit under trial
    logic [DW-1:0] result;    // Latched result on the outputs
    logic [DW-1:0] trial;     // Registered code under test
    logic          busy_n;    // Busy pin, low while converting
    logic          oe;        // Data bus drive enable
    logic          track;     // Sampling stage follows the input
  } acs_dev_t;

  acs_dev_t cur;
  acs_dev_t next_s;

  // Combined select from synchronised pins only
  logic sel;
  logic fall;
  assign sel  = ~cur.cs_s[1] & ~cur.rd_s[1];
  // A falling input clock is seen three core cycles late; every instant
  // shifts by the same amount, so sample spacing stays equal
  assign fall = cur.clk_d & ~cur.clk_s[1];

  // Next-state logic
  always_comb
  begin
    next_s       = cur;
    next_s.cs_s  = {cur.cs_s[0], link.cs_n};
    next_s.rd_s  = {cur.rd_s[0], link.rd_n};
    next_s.clk_s = {cur.clk_s[0], link.in_clk};
    next_s.clk_d = cur.clk_s[1];
    next_s.sel_d = sel;
    // Outputs float whenever the strobes are not both low
    next_s.oe    = sel;
    case (cur.st)
      ST_IDLE:
      begin
        next_s.track = 1'b1;
        if (sel && !cur.sel_d)
        begin
          // Strobe coincidence starts; the edge lands on a synchronised
          // sample, so a near-edge strobe may slip a clock.
          // Divider and counter restart with each conversion
          next_s.st     = ST_ACQ;
          next_s.busy_n = 1'b0;
          next_s.cnt    = '0;
          next_s.div    = 1'b0;
          next_s.successive_approx_register    = '0;
          next_s.bitm   = '0;
        end
      end
      ST_ACQ:
      begin
        // The divider runs only inside a conversion
        if (fall)
        begin
          next_s.cnt = cur.cnt + 1'b1;
          next_s.div = ~cur.div;
          // Third falling edge closes the hold switch.
          if (cur.cnt == CNT_W'(HOLD_EDGES - 1))
          begin
            next_s.track = 1'b0;
          end
          // Comparing begins after the settle interval.
          if (cur.cnt == CNT_W'(SETTLE_CYCLES + HOLD_EDGES - 2))
          begin
            next_s.st   = ST_CONV;
            next_s.bitm = {1'b1, {(DW-1){1'b0}}};
          end
        end
      end
      ST_CONV:
      begin
        if (fall)
        begin
          next_s.cnt = cur.cnt + 1'b1;
          next_s.div = ~cur.div;
          // Decide one bit per divided clock rising edge
          if (!cur.div && cur.bitm != '0)
          begin
            if (!cmp_high)
            begin
              next_s.successive_approx_register = cur.successive_approx_register | cur.bitm;
            end
            next_s.bitm = cur.bitm >> 1;
          end
          // Twenty input clocks end the run; the divider then stops
          // even though the input clock keeps toggling.
          // At the nominal input rate this is the minimum time.
          if (cur.cnt == CNT_W'(CONV_CYCLES - 1))
          begin
            next_s.st     = ST_GRACE;
            next_s.busy_n = 1'b1;
            next_s.track  = 1'b1;
            next_s.cnt    = '0;
            next_s.result = (!cmp_high && cur.bitm != '0)
                            ? (cur.successive_approx_register | cur.bitm) : cur.successive_approx_register;
          end
        end
      end
      ST_GRACE:
      begin
        // A read here only fetches data.
        // Window closes at the first falling edge after busy rises
        if (fall)
        begin
          if (cur.cnt == CNT_W'(REREAD_CYCLES - 1))
          begin
            next_s.st = ST_IDLE;
          end
          next_s.cnt = cur.cnt + 1'b1;
        end
        if (sel && !cur.sel_d)
        begin
          next_s.st = ST_IDLE;
          next_s.sel_d = 1'b1;
        end
      end
      default:
      begin
        next_s.st = ST_IDLE;
      end
    endcase
    // Register the trial code so the comparator sees a flop output
    next_s.trial = next_s.successive_approx_register | next_s.bitm;
  end

  // State register; result holds through a conversion.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      // Reset releases the bus and leaves the sampler tracking
      cur        <= '0;
      cur.cs_s   <= 2'b11;
      cur.rd_s   <= 2'b11;
      cur.sel_d  <= 1'b1;
      cur.st     <= ST_IDLE;
      cur.result <= RESULT_RST;
      cur.busy_n <= 1'b1;
      cur.track  <= 1'b1;
    end
    else if (core_ce)
    begin
      cur <= next_s;
    end
  end

  // Registered outputs
  assign link.busy_n  = cur.busy_n;
  assign link.data_o  = cur.result;
  assign link.data_oe = cur.oe;
  assign track        = cur.track;
  assign trial_code   = cur.trial;

endmodule // acs_converter

// *** hdl/acs_host.sv ***
`timescale 1ns/1ps
// Host end: makes the input clock, issues port reads
module acs_host
  import acs_pkg::*;
#(
  parameter int HALF = CORE_PER_IN_CLK / 2,  // Core cycles per half clock
  parameter int STROBE = 4                   // Core cycles strobes held
)(
  // Clock, enable, reset
  input  wire logic          core_clk,
  input  wire logic          core_ce,
  input  wire logic          rst_n,
  // User side
  input  wire logic          req,          // Hold high until ready falls: read the port once
  output logic               ready,        // High: a read may be requested
  output logic               rvalid,       // Pulse: rdata valid
  output logic [7:0]         rdata,        // Data read
  // Converter link
  acs_link_if.host           link
);

  // Host states, one-hot
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,   // Waiting for a request
    HS_RD   = 3'b010,   // Strobes low
    HS_WAIT = 3'b100    // Waiting for busy high
  } acs_hstate_t;

  // All state in one packed struct
  typedef struct packed {
    logic [1:0]  busy_s;   // Busy synchroniser
    logic [7:0]  div;      // Clock divider count
    logic        clk;      // Input clock, runs free
    acs_hstate_t st;
    logic [7:0]  cnt;      // Strobe width count
    logic        strobe;   // Strobes low
    logic        ready;
    logic        rvalid;
    logic [7:0]  rdata;
  } acs_host_t;

  acs_host_t cur;
  acs_host_t next_h;

  // Next-state logic
  always_comb
  begin
    next_h        = cur;
    next_h.busy_s = {cur.busy_s[0], link.busy_n};
    next_h.rvalid = 1'b0;
    // Free-running clock is allowed between conversions.
    if (cur.div == 8'(HALF - 1))
    begin
      next_h.div = '0;
      next_h.clk = ~cur.clk;
    end
    else
    begin
      next_h.div = cur.div + 8'h01;
    end
    case (cur.st)
      HS_IDLE:
      begin
        // Strobes drop together with a rising edge, far from a falling one
        if (req && cur.clk == 1'b0 && cur.div == 8'(HALF - 1))
        begin
          next_h.st     = HS_RD;
          next_h.strobe = 1'b1;
          next_h.cnt    = '0;
          next_h.ready  = 1'b0;
        end
      end
      HS_RD:
      begin
        next_h.cnt = cur.cnt + 8'h01;
        if (cur.cnt == 8'(STROBE - 1))
        begin
          next_h.strobe = 1'b0;
          next_h.rdata  = link.data;
          next_h.rvalid = 1'b1;
          next_h.st     = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        // The busy synchroniser still shows the level from before the
        // start for a few cycles; trust it only after that. STROBE must
        // be at least three for this guard to cover the lag.
        if (cur.cnt < 8'(STROBE + 2))
        begin
          next_h.cnt = cur.cnt + 8'h01;
        end
        // No new read until busy returns high; this also keeps the
        // bus quiet while converting.
        else if (cur.busy_s[1])
        begin
          next_h.st    = HS_IDLE;
          next_h.ready = 1'b1;
        end
      end
      default:
      begin
        next_h.st = HS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cur        <= '0;
      cur.busy_s <= 2'b11;
      cur.st     <= HS_IDLE;
      cur.ready  <= 1'b1;
    end
    else if (core_ce)
    begin
      cur <= next_h;
    end
  end

  // Registered outputs
  assign link.cs_n   = ~cur.strobe;
  assign link.rd_n   = ~cur.strobe;
  assign link.in_clk = cur.clk;
  assign ready       = cur.ready;
  assign rvalid      = cur.rvalid;
  assign rdata       = cur.rdata;

endmodule // acs_host

// *** hdl/acs_link_if.sv ***
`timescale 1ns/1ps
// Pins between host and converter; data bus resolved from enables
interface acs_link_if;
  logic       cs_n;        // Chip select, active low
  logic       rd_n;        // Read strobe, active low
  logic       busy_n;      // Converter busy, active low
  logic [7:0] data_o;      // Converter drive onto data bus
  logic       data_oe;     // Converter drives data bus
  logic       in_clk;      // Converter input clock from host

  // Bus level seen by host: floats to zero when undriven
  logic [7:0] data;
  assign data = data_oe ? data_o : 8'h00;

  modport device (
    input  cs_n,
    input  rd_n,
    input  in_clk,
    output busy_n,
    output data_o,
    output data_oe
  );

  modport host (
    output cs_n,
    output rd_n,
    output in_clk,
    input  busy_n,
    input  data
  );
endinterface : acs_link_if

// *** hdl/acs_pkg.sv ***
package acs_pkg;

  // Converter resolution
  localparam int DATA_W = 8;

  // Conversion clock divider: input clock divided by two
  localparam int CLK_DIV = 2;

  // Falling input-clock edges from start to the hold instant
  localparam int HOLD_EDGES = 3;

  // Input-clock cycles of a full conversion
  localparam int CONV_CYCLES = 20;

  // Internal (divided) clock cycles of a full conversion
  localparam int CONV_INT_CYCLES = CONV_CYCLES / CLK_DIV;

  // Input-clock cycles before the first comparator decision
  localparam int SETTLE_CYCLES = 2;

  // Window after busy rises during which a read starts nothing, in cycles
  localparam int REREAD_CYCLES = 1;

  // Strobe uncertainty window against a falling edge
  localparam int SKEW_NS = 20;

  // Nominal input clock for the specified conversion time
  localparam int NOM_CLK_MHZ = 4;

  // Core clock period
  localparam int CORE_PERIOD_NS = 10;

  // Core clock cycles per input clock cycle (derived default)
  localparam int CORE_PER_IN_CLK = 1000 / (NOM_CLK_MHZ * CORE_PERIOD_NS);

  // Width of the cycle counter
  localparam int CNT_W = 6;

  // Reset value of the result latch
  localparam logic [7:0] RESULT_RST = 8'h00;

endpackage : acs_pkg

// *** testbench/acs_link_assertions.sv ***
`timescale 1ns/1ps
// Watches the link pins between host and converter
module acs_link_assertions (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Link pins
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       busy_n,
  input wire logic [7:0] data_o,
  input wire logic       data_oe,
  input wire logic       in_clk
);
  logic [9:0] low_cnt; // Core cycles spent converting

  // Busy length counter; saturates so an overlong busy cannot wrap back into range
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || busy_n)
      low_cnt <= 10'h000;
    else if (low_cnt != 10'h3ff)
      low_cnt <= low_cnt + 10'h001;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_strobe_pair;
    cs_n == rd_n;
  endproperty
  a_strobe_pair: assert property (p_strobe_pair)
    else $error("chip select and read strobe differ");
  property p_busy_cause;
    $fell(busy_n) |-> $past(!cs_n && !rd_n, 3);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy fell without a start three cycles before");
  // Twenty input clocks of 24 core cycles, start phase unknown
  property p_busy_len;
    $rose(busy_n) |-> low_cnt >= 10'd440 && low_cnt <= 10'd500;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("conversion length out of range");
  property p_host_wait;
    $fell(cs_n) |-> busy_n;
  endproperty
  a_host_wait: assert property (p_host_wait)
    else $error("host started while converting");
  property p_no_restart;
    $rose(busy_n) |-> busy_n [*8] ##1 busy_n [*8] ##1 busy_n [*8];
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("conversion restarted right after completion");
  property p_oe_sel;
    data_oe |-> $past(!cs_n && !rd_n, 3);
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("data driven without select");
  property p_data_hold;
    data_oe && $past(data_oe) |-> $stable(data_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("driven data changed during a read");
  property p_data_upd;
    $changed(data_o) |-> $rose(busy_n);
  endproperty
  a_data_upd: assert property (p_data_upd)
    else $error("result changed away from completion");
  property p_clk_run;
    $rose(in_clk) |-> ##12 $fell(in_clk);
  endproperty
  a_clk_run: assert property (p_clk_run)
    else $error("input clock half period wrong");
endmodule // acs_link_assertions

// *** testbench/acs_sequencer_tb.sv ***
`timescale 1ns/1ps
// Host and converter joined; random levels on a model comparator
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  logic       core_clk = 1'b0;  // 100 MHz clock
  logic       rst_n    = 1'b0;  // Sync reset
  logic       req      = 1'b0;  // Host read request, held until ready falls
  logic       ready;            // Host may read
  logic       rvalid;           // Read data valid
  logic       track;            // Sampling stage follows input
  logic       cmp_high;         // Comparator output
  logic [7:0] rdata;            // Data read by host
  logic [7:0] trial_code;       // Level under test
  logic [7:0] ain      = 8'h00; // Analog input, as a code
  logic [7:0] held     = 8'h00; // Level on the hold capacitor
  logic [7:0] want;             // Result expected next
  logic [7:0] d;                // Data of one read
  logic [7:0] rnd      = 8'h11; // Random state, starts at 17
  int         fail_count = 0;
  int         checked    = 0;
  int         n;

  acs_link_if link ();

  acs_converter acs_converter_i (.core_clk(core_clk), .core_ce(1'b1),
    .rst_n(rst_n), .link(link), .cmp_high(cmp_high), .track(track),
    .trial_code(trial_code));

  acs_host acs_host_i (.core_clk(core_clk), .core_ce(1'b1),
    .rst_n(rst_n), .req(req), .ready(ready), .rvalid(rvalid),
    .rdata(rdata), .link(link));

  acs_link_assertions acs_link_assertions_i (.core_clk(core_clk),
    .rst_n(rst_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .busy_n(link.busy_n), .data_o(link.data_o),
    .data_oe(link.data_oe), .in_clk(link.in_clk));

  always #5 core_clk = ~core_clk;

  // Hold capacitor follows the input only while tracking
  always @(posedge core_clk)
    if (track)
      held <= ain;

  // Ideal comparator: high when trial code is above the held level
  assign cmp_high = trial_code > held;

  // Random source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Ideal successive approximation of a level, MSB first
  function automatic logic [7:0] sar_ref(input logic [7:0] lvl);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
      if ((c | (8'h01 << b)) <= lvl)
        c = c | (8'h01 << b);
    return c;
  endfunction

  // Level of the watched condition
  function automatic logic cond(input int k);
    case (k)
      0: return ready;
      1: return rvalid;
      3: return !ready;
      default: return !track;
    endcase
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_cond(input int k);
    n = 0;
    while (cond(k) !== 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 2000)
    begin
      fail_count++;
      stop_test();
    end
  endtask

  // One port read: starts a conversion unless inside the re-read window, returns the older result
  task automatic do_read(output logic [7:0] r);
    wait_cond(0);
    @(posedge core_clk);
    // Hold the request until the host takes it at its clock phase
    req <= 1'b1;
    wait_cond(3);
    @(posedge core_clk);
    req <= 1'b0;
    wait_cond(1);
    r = rdata;
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    want = 8'h00;
    do_read(d);
    check("first read", d, RESULT_RST);
    for (int i = 0; i < 12; i++)
    begin
      // Upset the input once held; result must not see it
      wait_cond(2);
      ain <= ~want;
      wait_cond(0);
      // Read at once after completion: fetches, starts nothing
      if (i == 5)
      begin
        do_read(d);
        check("re-read", d, want);
        check("no restart", {7'h00, link.busy_n}, 8'h01);
      end
      // Leave the re-read window so the next read starts anew
      repeat (40) @(posedge core_clk);
      rnd = lfsr(rnd);
      ain <= (i == 0) ? 8'hff : rnd;
      @(posedge core_clk);
      do_read(d);
      check("result", d, want);
      want = sar_ref(ain);
    end
    stop_test();
  end
endmodule // adc_conversion_sequencer_tb
